// file: logic/dgvic_top.sv
`timescale 1ns/1ps
`default_nettype none
module dgvic_top
    import dgvic_pkg::*;
#(
    parameter int PULSE_CYC = FILTER_CYC
)(
    input  wire logic        CORE_CLK_I,
    input  wire logic        SYS_RST_I,
    input  wire logic        BUS_INIT_I,
    input  wire logic [1:0]  BUS_ADDR_I,
    input  wire logic        BUS_DIN_I,
    input  wire logic        BUS_DOUT_I,
    input  wire logic [15:0] BUS_DATA_I,
    output logic      [15:0] BUS_DATA_O,
    output logic             BUS_DATA_OE_N_O,
    output logic             BUS_RPLY_O,
    output logic             BUS_IRQ4_O,
    input  wire logic        BUS_IACK_IN_I,
    output logic             BUS_IACK_OUT_O,
    input  wire logic [15:0] REQ_LINE_I,
    input  wire logic [3:0]  USER_RDY_I,
    output logic      [3:0]  DEV_RDY_O,
    output logic      [3:0]  PORT_OE_N_O
);
    if (PULSE_CYC <= REJECT_CYC + 1 || PULSE_CYC + 2 >= ACCEPT_CYC) begin : g_chk
        $error("dgvic_top: PULSE_CYC outside the accept and reject window");
    end

    // Input synchronisers for every asynchronous bus and user pin.
    dgvic_pin_t pin_raw;
    dgvic_pin_t sync1_r;
    dgvic_pin_t pin;
    logic       din_prev_r;
    logic       dout_prev_r;
    logic       iack_prev_r;

    assign pin_raw = '{init: BUS_INIT_I, din: BUS_DIN_I, dout: BUS_DOUT_I, iack: BUS_IACK_IN_I,
                       addr: BUS_ADDR_I, data: BUS_DATA_I, rdy: USER_RDY_I};

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            sync1_r <= '0;
            pin     <= '0;
        end else begin
            sync1_r <= pin_raw;
            pin     <= sync1_r;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            din_prev_r  <= 1'b0;
            dout_prev_r <= 1'b0;
            iack_prev_r <= 1'b0;
        end else begin
            din_prev_r  <= pin.din;
            dout_prev_r <= pin.dout;
            iack_prev_r <= pin.iack;
        end
    end

    logic din_rise;
    logic dout_rise;
    logic iack_rise;

    assign din_rise  = pin.din & ~din_prev_r;
    assign dout_rise = pin.dout & ~dout_prev_r;
    assign iack_rise = pin.iack & ~iack_prev_r;

    // Group state and request qualification.
    dgvic_grp_t   grp_r   [NGRP];
    dgvic_grp_t   grp_nxt [NGRP];
    logic [7:0]   req_set [NGRP];
    logic [7:0]   pend    [NGRP];
    logic [NGRP-1:0] gint;
    logic         chain_enable_out;
    logic         chain_enable_in;

    for (genvar g = 0; g < NGRP; g++) begin : g_grp
        dgvic_req_filter #(
            .NL  (NLINE),
            .THR (PULSE_CYC)
        ) u_filter (
            .clk_i    (CORE_CLK_I),
            .rst_i    (SYS_RST_I),
            .line_i   (REQ_LINE_I[g*NLINE +: NLINE]),
            .rising_i (grp_r[g].rising),
            .set_o    (req_set[g])
        );

        assign pend[g] = grp_r[g].req & ~grp_r[g].mask;
        assign gint[g] = grp_r[g].armed & (|pend[g]);
    end

    assign chain_enable_out = grp_r[0].armed;
    assign chain_enable_in  = chain_enable_out;

    // Bus and acknowledge sequencing.
    dgvic_state_t state_r;
    logic         allow_r;
    logic [3:0]   dir_r;
    logic         irq_r;
    logic         ack_r;
    logic         ack_grp_r;
    logic [2:0]   ack_lvl_r;
    logic [1:0]   bus_addr_r;
    logic [15:0]  data_o_r;
    logic         oe_n_r;
    logic         rply_r;
    logic         iack_out_r;
    logic [3:0]   dev_rdy_r;
    logic [3:0]   port_oe_n_r;
    logic         irq_nxt;
    logic         win_grp;
    logic [2:0]   win_lvl;

    // Group 2 takes part only while group 1 passes its enable along.
    assign irq_nxt = allow_r & (gint[0] | (gint[1] & chain_enable_in));
    assign win_grp = ~gint[0];
    assign win_lvl = gint[0] ? dgvic_first(pend[0]) : dgvic_first(pend[1]);

    logic wr_en;
    logic wr_cmd;
    logic wr_win;
    logic wr_grp;
    logic [7:0] wbyte;
    logic ack_done;

    assign wr_en    = (state_r == ST_IDLE) & dout_rise & ~iack_rise;
    assign wr_cmd   = wr_en & ~pin.addr[0];
    assign wr_win   = wr_en & pin.addr[0];
    assign wr_grp   = pin.addr[1];
    assign wbyte    = pin.data[7:0];
    assign ack_done = (state_r == ST_LOAD) & ack_r;

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (iack_rise) begin
                        state_r <= irq_r ? ST_FETCH : ST_PASS;
                    end else if (din_rise) begin
                        state_r <= ST_FETCH;
                    end else if (dout_rise) begin
                        state_r <= ST_HOLD;
                    end
                end
                ST_FETCH: state_r <= ST_LOAD;
                ST_LOAD:  state_r <= ST_HOLD;
                ST_PASS: begin
                    if (!pin.iack) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_HOLD: begin
                    if (!pin.din && !pin.dout && !pin.iack) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            ack_r      <= 1'b0;
            ack_grp_r  <= 1'b0;
            ack_lvl_r  <= 3'h0;
            bus_addr_r <= WORD_A;
        end else if (state_r == ST_IDLE) begin
            ack_r <= iack_rise & irq_r;
            if (iack_rise) begin
                ack_grp_r <= win_grp;
                ack_lvl_r <= win_lvl;
            end else if (din_rise || dout_rise) begin
                bus_addr_r <= pin.addr;
            end
        end
    end

    // Vector memory: one shared array, group in the top address bit.
    logic [3:0] mem_raddr;
    logic [7:0] mem_rdata;

    assign mem_raddr = ack_r ? {ack_grp_r, ack_lvl_r} : {bus_addr_r[1], grp_r[bus_addr_r[1]].ptr};

    dgvic_vec_mem #(
        .DW    (8),
        .DEPTH (16),
        .AW    (4)
    ) u_vec_mem (
        .clk_i   (CORE_CLK_I),
        .we_i    (wr_win && grp_r[wr_grp].win == WIN_VEC),
        .waddr_i ({wr_grp, grp_r[wr_grp].ptr}),
        .wdata_i (wbyte),
        .raddr_i (mem_raddr),
        .rdata_o (mem_rdata)
    );

    // Read word composition.
    logic [7:0]  stat_byte;
    logic [7:0]  win_byte;
    logic [15:0] rd_word;
    dgvic_grp_t  rg;

    always_comb begin
        rg        = grp_r[bus_addr_r[1]];
        stat_byte = 8'h00;
        stat_byte[ST_ARMED] = rg.armed;
        stat_byte[ST_GINT]  = gint[bus_addr_r[1]];
        stat_byte[ST_RISE]  = rg.rising;
        stat_byte[ST_ANY]   = |(rg.req & ~rg.mask);
        stat_byte[2:0]      = dgvic_first(rg.req & ~rg.mask);
        case (rg.win)
            WIN_REQ:  win_byte = rg.req;
            WIN_SVC:  win_byte = rg.svc;
            WIN_ACLR: win_byte = rg.aclr;
            WIN_MASK: win_byte = rg.mask;
            WIN_VEC:  win_byte = mem_rdata;
            default:  win_byte = 8'h00;
        endcase
        rd_word = 16'h0000;
        if (ack_r) begin
            rd_word[7:0] = mem_rdata;
        end else begin
            rd_word[7:0]   = bus_addr_r[0] ? win_byte : stat_byte;
            rd_word[BIT_DIR]   = dir_r[bus_addr_r];
            rd_word[BIT_ALLOW] = (bus_addr_r == WORD_A) & allow_r;
            rd_word[BIT_RDY]   = pin.rdy[bus_addr_r];
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            data_o_r <= 16'h0000;
            oe_n_r   <= 1'b1;
            rply_r   <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    rply_r <= wr_en;
                end
                ST_LOAD: begin
                    data_o_r <= rd_word;
                    oe_n_r   <= 1'b0;
                    rply_r   <= 1'b1;
                end
                ST_HOLD: begin
                    if (!pin.din && !pin.dout && !pin.iack) begin
                        oe_n_r <= 1'b1;
                        rply_r <= 1'b0;
                    end
                end
                default: begin
                    oe_n_r <= 1'b1;
                    rply_r <= 1'b0;
                end
            endcase
        end
    end

    // Acknowledge is passed down the chain when irq_r is low, even if an armed group has a line pending.
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            iack_out_r <= 1'b0;
            irq_r      <= 1'b0;
        end else begin
            iack_out_r <= (state_r == ST_PASS) & pin.iack;
            irq_r      <= irq_nxt & ~ack_r;
        end
    end

    // Group latches; initialize leaves them alone.
    always_comb begin
        for (int g = 0; g < NGRP; g++) begin
            grp_nxt[g] = grp_r[g];
            if (wr_cmd && wr_grp == 1'(g)) begin
                case (wbyte[7:4])
                    OP_SEL_WIN: begin
                        if (wbyte[2:0] <= WIN_MASK) begin
                            grp_nxt[g].win = dgvic_win_t'(wbyte[2:0]);
                        end
                    end
                    OP_SEL_VEC: begin
                        grp_nxt[g].win = WIN_VEC;
                        grp_nxt[g].ptr = wbyte[2:0];
                    end
                    OP_ARM:    grp_nxt[g].armed = 1'b1;
                    OP_DISARM: grp_nxt[g].armed = 1'b0;
                    OP_EDGE:   grp_nxt[g].rising = wbyte[0];
                    OP_CLEAR: begin
                        grp_nxt[g].req = 8'h00;
                        grp_nxt[g].svc = 8'h00;
                    end
                    default: grp_nxt[g] = grp_r[g];
                endcase
            end
            if (wr_win && wr_grp == 1'(g)) begin
                case (grp_r[g].win)
                    WIN_REQ:  grp_nxt[g].req  = wbyte;
                    WIN_SVC:  grp_nxt[g].svc  = wbyte;
                    WIN_ACLR: grp_nxt[g].aclr = wbyte;
                    WIN_MASK: grp_nxt[g].mask = wbyte;
                    default:  grp_nxt[g].mask = grp_r[g].mask;
                endcase
            end
            if (ack_done && ack_grp_r == 1'(g)) begin
                grp_nxt[g].req[ack_lvl_r] = 1'b0;
                grp_nxt[g].svc[ack_lvl_r] = ~grp_r[g].aclr[ack_lvl_r];
            end
            // A fresh edge in the clearing cycle still lands.
            grp_nxt[g].req = grp_nxt[g].req | req_set[g];
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        for (int g = 0; g < NGRP; g++) begin
            if (SYS_RST_I) begin
                grp_r[g] <= GRP_RST;
            end else begin
                grp_r[g] <= grp_nxt[g];
            end
        end
    end

    // Direction and allow bits.
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            dir_r   <= 4'h0;
            allow_r <= 1'b0;
        end else if (pin.init) begin
            dir_r   <= 4'h0;
            allow_r <= 1'b0;
        end else if (wr_en) begin
            dir_r[pin.addr] <= pin.data[BIT_DIR];
            if (pin.addr == WORD_A) begin
                allow_r <= pin.data[BIT_ALLOW];
            end
        end
    end

    // Port drivers only open with direction set and the user ready.
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            dev_rdy_r   <= 4'hF;
            port_oe_n_r <= 4'hF;
        end else begin
            dev_rdy_r   <= ~dir_r;
            port_oe_n_r <= ~(dir_r & pin.rdy);
        end
    end

    assign BUS_DATA_O      = data_o_r;
    assign BUS_DATA_OE_N_O = oe_n_r;
    assign BUS_RPLY_O      = rply_r;
    assign BUS_IRQ4_O      = irq_r;
    assign BUS_IACK_OUT_O  = iack_out_r;
    assign DEV_RDY_O       = dev_rdy_r;
    assign PORT_OE_N_O     = port_oe_n_r;
endmodule : dgvic_top
`default_nettype wire

// file: common/dgvic_pkg.sv
package dgvic_pkg;

    localparam int NGRP  = 2;
    localparam int NLINE = 8;

    // Control word select on the bus address pins.
    localparam logic [1:0] WORD_A = 2'h0;
    localparam logic [1:0] WORD_B = 2'h1;
    localparam logic [1:0] WORD_C = 2'h2;
    localparam logic [1:0] WORD_D = 2'h3;

    localparam int BIT_DIR   = 8;
    localparam int BIT_ALLOW = 9;
    localparam int BIT_RDY   = 15;

    // Status byte fields.
    localparam int ST_ARMED = 7;
    localparam int ST_GINT  = 6;
    localparam int ST_RISE  = 5;
    localparam int ST_ANY   = 3;

    // Command byte: opcode in the high nibble, argument in bits 2:0.
    localparam logic [3:0] OP_SEL_WIN = 4'h1;
    localparam logic [3:0] OP_SEL_VEC = 4'h2;
    localparam logic [3:0] OP_ARM     = 4'h3;
    localparam logic [3:0] OP_DISARM  = 4'h4;
    localparam logic [3:0] OP_EDGE    = 4'h5;
    localparam logic [3:0] OP_CLEAR   = 4'h6;

    localparam int CORE_CLK_MHZ    = 100;
    localparam int PULSE_REJECT_NS = 30;
    localparam int PULSE_ACCEPT_NS = 270;
    localparam int REJECT_CYC      = (PULSE_REJECT_NS * CORE_CLK_MHZ) / 1000;
    localparam int ACCEPT_CYC      = (PULSE_ACCEPT_NS * CORE_CLK_MHZ + 999) / 1000;
    localparam int FILTER_CYC      = (REJECT_CYC + ACCEPT_CYC) / 2;

    typedef enum logic [2:0] {
        WIN_REQ  = 3'h0,
        WIN_SVC  = 3'h1,
        WIN_ACLR = 3'h2,
        WIN_MASK = 3'h3,
        WIN_VEC  = 3'h4
    } dgvic_win_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_FETCH = 3'h1,
        ST_LOAD  = 3'h2,
        ST_HOLD  = 3'h3,
        ST_PASS  = 3'h4
    } dgvic_state_t;

    typedef struct packed {
        logic       armed;
        logic       rising;
        dgvic_win_t win;
        logic [2:0] ptr;
        logic [7:0] req;
        logic [7:0] svc;
        logic [7:0] aclr;
        logic [7:0] mask;
    } dgvic_grp_t;

    localparam dgvic_grp_t GRP_RST = '{armed: 1'b0, rising: 1'b1, win: WIN_REQ, ptr: 3'h0,
                                       req: 8'h00, svc: 8'h00, aclr: 8'h00, mask: 8'hFF};

    typedef struct packed {
        logic        init;
        logic        din;
        logic        dout;
        logic        iack;
        logic [1:0]  addr;
        logic [15:0] data;
        logic [3:0]  rdy;
    } dgvic_pin_t;

    // Lowest numbered pending line wins.
    function automatic logic [2:0] dgvic_first(input logic [7:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction : dgvic_first

endpackage : dgvic_pkg

// file: logic/dgvic_vec_mem.sv
`timescale 1ns/1ps
`default_nettype none
module dgvic_vec_mem #(
    parameter int DW    = 8,
    parameter int DEPTH = 16,
    parameter int AW    = 4
)(
    input  wire logic          clk_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [DW-1:0] wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output var  logic [DW-1:0] rdata_o
);
    if (DEPTH > (1 << AW) || DEPTH < 1) begin : g_chk
        $error("dgvic_vec_mem: DEPTH does not fit AW");
    end

    // Contents are not reset; software loads every vector before arming.
    logic [DW-1:0] mem_r [DEPTH];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_r[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        rdata_o <= mem_r[raddr_i];
    end
endmodule : dgvic_vec_mem
`default_nettype wire

// file: logic/dgvic_req_filter.sv
`timescale 1ns/1ps
`default_nettype none
module dgvic_req_filter #(
    parameter int NL  = 8,
    parameter int THR = 15
)(
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic [NL-1:0] line_i,
    input  wire logic          rising_i,
    output var  logic [NL-1:0] set_o
);
    localparam int CW = $clog2(THR + 1);

    if (THR < 2) begin : g_chk
        $error("dgvic_req_filter: THR must be at least 2");
    end

    logic [NL-1:0] sync1_r;
    logic [NL-1:0] sync2_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= line_i;
            sync2_r <= sync1_r;
        end
    end

    for (genvar i = 0; i < NL; i++) begin : g_line
        logic          act;
        logic [CW-1:0] cnt_r;

        assign act = rising_i ? sync2_r[i] : ~sync2_r[i];

        // Starting saturated makes a line active at reset need an idle phase in falling mode; in rising mode the zeroed sync stages clear the count.
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                cnt_r    <= CW'(THR);
                set_o[i] <= 1'b0;
            end else begin
                set_o[i] <= act && (cnt_r == CW'(THR - 1));
                if (!act) begin
                    cnt_r <= '0;
                end else if (cnt_r != CW'(THR)) begin
                    cnt_r <= cnt_r + CW'(1);
                end
            end
        end
    end
endmodule : dgvic_req_filter
`default_nettype wire

// file: testbench/dgvic_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dgvic_asserts (
    input wire logic        CORE_CLK_I,
    input wire logic        SYS_RST_I,
    input wire logic        BUS_INIT_I,
    input wire logic [1:0]  BUS_ADDR_I,
    input wire logic        BUS_DIN_I,
    input wire logic [15:0] BUS_DATA_O,
    input wire logic        BUS_DATA_OE_N_O,
    input wire logic        BUS_RPLY_O,
    input wire logic        BUS_IRQ4_O,
    input wire logic        BUS_IACK_IN_I,
    input wire logic        BUS_IACK_OUT_O,
    input wire logic [3:0]  USER_RDY_I,
    input wire logic [3:0]  DEV_RDY_O,
    input wire logic [3:0]  PORT_OE_N_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    // Pins pass two sync stages, so pin-to-output relations wait a few edges.
    init_dir_a: assert property (BUS_INIT_I [*5] |-> DEV_RDY_O == 4'hF)
        else $error("init left a direction set");
    init_allow_a: assert property (BUS_INIT_I [*6] |-> !BUS_IRQ4_O)
        else $error("init left requests allowed");
    dir_gate_a: assert property ((DEV_RDY_O & ~PORT_OE_N_O) == 4'h0)
        else $error("input port drives");
    usr_gate_a: assert property ($stable(USER_RDY_I) [*5] |-> (~USER_RDY_I & ~PORT_OE_N_O) == 4'h0)
        else $error("port drives without user ready");
    vec_width_a: assert property ($rose(BUS_RPLY_O) && !BUS_DATA_OE_N_O && BUS_IACK_IN_I |-> BUS_DATA_O[15:8] == 8'h00)
        else $error("vector upper byte not zero");
    zero_bits_a: assert property ($rose(BUS_RPLY_O) && BUS_DIN_I && BUS_ADDR_I[1] |-> BUS_DATA_O[14:9] == 6'h00)
        else $error("unused bits not zero");
    data_hold_a: assert property (BUS_RPLY_O && $past(BUS_RPLY_O) && !BUS_DATA_OE_N_O |-> $stable(BUS_DATA_O))
        else $error("read data moved during reply");
    rply_hold_a: assert property (BUS_RPLY_O && BUS_DIN_I |=> BUS_RPLY_O)
        else $error("reply dropped under data-in");
    pass_quiet_a: assert property (BUS_IACK_OUT_O |-> BUS_DATA_OE_N_O && !BUS_RPLY_O)
        else $error("passed acknowledge also answered");
    pass_cause_a: assert property ($rose(BUS_IACK_OUT_O) |-> $past(BUS_IACK_IN_I, 2))
        else $error("chain out without chain in");
    cover property ($rose(BUS_IRQ4_O));
    cover property ($rose(BUS_RPLY_O) && BUS_IACK_IN_I);
    cover property ($rose(BUS_IACK_OUT_O));
endmodule : dgvic_asserts
bind dgvic_top dgvic_asserts u_chk (
    .CORE_CLK_I(CORE_CLK_I), .SYS_RST_I(SYS_RST_I), .BUS_INIT_I(BUS_INIT_I),
    .BUS_ADDR_I(BUS_ADDR_I), .BUS_DIN_I(BUS_DIN_I), .BUS_DATA_O(BUS_DATA_O),
    .BUS_DATA_OE_N_O(BUS_DATA_OE_N_O), .BUS_RPLY_O(BUS_RPLY_O), .BUS_IRQ4_O(BUS_IRQ4_O),
    .BUS_IACK_IN_I(BUS_IACK_IN_I), .BUS_IACK_OUT_O(BUS_IACK_OUT_O), .USER_RDY_I(USER_RDY_I),
    .DEV_RDY_O(DEV_RDY_O), .PORT_OE_N_O(PORT_OE_N_O));
`default_nettype wire

// file: testbench/dgvic_host.sv
`timescale 1ns/1ps
`default_nettype none
module dgvic_host (
    input  wire logic   clk_i,
    input  wire logic   rply_i,
    input  wire logic   pass_i,
    output logic        din_o,
    output logic        dout_o,
    output logic        iack_o,
    output logic [1:0]  addr_o,
    output logic [15:0] data_o
);
    // Counts answers that never came, so a stalled handshake cannot end in a pass.
    int n_to;
    initial begin
        n_to = 0;
        din_o = 1'b0;
        dout_o = 1'b0;
        iack_o = 1'b0;
        addr_o = 2'h0;
        data_o = 16'h0000;
    end
    task automatic wt(input logic lvl);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while ((rply_i | pass_i) !== lvl && n < 200);
        if ((rply_i | pass_i) !== lvl) begin
            n_to++;
        end
    endtask : wt
    // Every qualifier stands until the answer is sampled at a rising edge.
    task automatic xfer(input logic [1:0] a, input logic [15:0] d, input logic w);
        @(posedge clk_i);
        addr_o <= a;
        data_o <= d;
        dout_o <= w;
        din_o <= ~w;
        wt(1'b1);
        dout_o <= 1'b0;
        din_o <= 1'b0;
        // Released lines flip so a stale value is never mistaken for data.
        data_o <= ~d;
        wt(1'b0);
    endtask : xfer
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        xfer(a, d, 1'b1);
    endtask : wr
    task automatic rd(input logic [1:0] a);
        xfer(a, ~data_o, 1'b0);
    endtask : rd
    task automatic ack(output logic p);
        @(posedge clk_i);
        iack_o <= 1'b1;
        wt(1'b1);
        p = pass_i;
        iack_o <= 1'b0;
        wt(1'b0);
    endtask : ack
endmodule : dgvic_host
`default_nettype wire

// file: testbench/dgvic_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module dgvic_top_test
    import dgvic_pkg::*;
;
    localparam int PC = 8;
    logic        clk;
    logic        rst;
    logic        init;
    logic [15:0] req;
    logic [3:0]  usr;
    logic        din;
    logic        dout;
    logic        iack;
    logic [1:0]  addr;
    logic [15:0] wdat;
    logic [15:0] rdat;
    logic        oe_n;
    logic        rply;
    logic        irq;
    logic        pass;
    logic [3:0]  dev_rdy;
    logic [3:0]  port_oe_n;
    logic        rply_d;
    logic        p;
    logic [7:0]  v;
    logic [31:0] e;
    logic [31:0] exp_q[$];
    int          n_errors;
    int          cmp_count;
    int          cyc;
    dgvic_top #(.PULSE_CYC(PC)) DUT (
        .CORE_CLK_I(clk), .SYS_RST_I(rst), .BUS_INIT_I(init), .BUS_ADDR_I(addr),
        .BUS_DIN_I(din), .BUS_DOUT_I(dout), .BUS_DATA_I(wdat), .BUS_DATA_O(rdat),
        .BUS_DATA_OE_N_O(oe_n), .BUS_RPLY_O(rply), .BUS_IRQ4_O(irq), .BUS_IACK_IN_I(iack),
        .BUS_IACK_OUT_O(pass), .REQ_LINE_I(req), .USER_RDY_I(usr), .DEV_RDY_O(dev_rdy),
        .PORT_OE_N_O(port_oe_n));
    dgvic_host h (.clk_i(clk), .rply_i(rply), .pass_i(pass), .din_o(din), .dout_o(dout),
        .iack_o(iack), .addr_o(addr), .data_o(wdat));
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        init = 1'b0;
        req = 16'h0000;
        usr = 4'h0;
        rply_d = 1'b0;
        n_errors = 0;
        cmp_count = 0;
        cyc = 0;
    end
    always #5 clk = ~clk;
    task automatic close_out();
        if (exp_q.size() != 0 || h.n_to != 0) begin
            miss("reply missing");
        end
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic miss(input string s);
        n_errors++;
        $display("mismatch at %0t: %s", $time, s);
    endtask : miss
    task automatic cmp_rd(input logic [15:0] g, input logic [31:0] x);
        cmp_count++;
        if ((g & x[15:0]) !== (x[31:16] & x[15:0])) begin
            miss("read data");
        end
    endtask : cmp_rd
    task automatic cmp_pin(input logic [3:0] g, input logic [3:0] x);
        cmp_count++;
        if (g !== x) begin
            miss("port pins");
        end
    endtask : cmp_pin
    task automatic cmp_bit(input logic g, input logic x);
        cmp_count++;
        if (g !== x) begin
            miss("single pin");
        end
    endtask : cmp_bit
    task automatic rd_chk(input logic [1:0] a, input logic [15:0] x, input logic [15:0] m);
        exp_q.push_back({x, m});
        h.rd(a);
    endtask : rd_chk
    always @(posedge clk) begin
        if (rply === 1'b1 && rply_d === 1'b0 && oe_n === 1'b0) begin
            if (exp_q.size() == 0) begin
                miss("unexpected reply");
            end else begin
                e = exp_q.pop_front();
                cmp_rd(rdat, e);
            end
        end
        rply_d <= rply;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_errors++;
            close_out();
        end
    end
    initial begin
        void'($urandom(32'hB368));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        cmp_pin(dev_rdy, 4'hF);
        cmp_pin(port_oe_n, 4'hF);
        usr <= 4'h4;
        h.wr(WORD_C, {8'hFF, OP_ARM, 4'h0});
        rd_chk(WORD_C, 16'h8180, 16'hFF80);
        cmp_pin(dev_rdy, 4'hB);
        cmp_pin(port_oe_n, 4'hB);
        usr <= 4'h0;
        repeat (5) @(posedge clk);
        cmp_pin(port_oe_n, 4'hF);
        rd_chk(WORD_C, 16'h0180, 16'hFF80);
        init <= 1'b1;
        repeat (8) @(posedge clk);
        init <= 1'b0;
        cmp_pin(dev_rdy, 4'hF);
        rd_chk(WORD_C, 16'h0080, 16'hFF80);
        h.wr(WORD_C, {8'h00, OP_SEL_WIN, 4'h3});
        h.wr(WORD_D, 16'h00FA);
        rd_chk(WORD_D, 16'h00FA, 16'hFFFF);
        v = 8'($urandom());
        h.wr(WORD_C, {8'h00, OP_SEL_VEC, 4'h0});
        h.wr(WORD_D, {8'h00, v});
        rd_chk(WORD_D, {8'h00, v}, 16'hFFFF);
        // Group 1 is armed with no lines in use so its chain enable reaches group 2.
        h.wr(WORD_A, {6'h00, 2'h2, OP_ARM, 4'h0});
        h.wr(WORD_C, {8'h00, OP_SEL_WIN, 4'h0});
        cmp_bit(irq, 1'b0);
        req[8] <= 1'b1;
        req[10] <= 1'b1;
        repeat (PC + 8) @(posedge clk);
        req[8] <= 1'b0;
        req[10] <= 1'b0;
        req[9] <= 1'b1;
        repeat (2) @(posedge clk);
        req[9] <= 1'b0;
        repeat (30) @(posedge clk);
        rd_chk(WORD_D, 16'h0005, 16'h00FF);
        cmp_bit(irq, 1'b1);
        exp_q.push_back({8'h00, v, 16'hFFFF});
        h.ack(p);
        cmp_bit(p, 1'b0);
        rd_chk(WORD_D, 16'h0004, 16'h00FF);
        cmp_bit(irq, 1'b1);
        init <= 1'b1;
        repeat (8) @(posedge clk);
        init <= 1'b0;
        cmp_bit(irq, 1'b0);
        rd_chk(WORD_A, 16'h0080, 16'h8380);
        // Line 2 is still pending, so only its mask can keep the request down now.
        h.wr(WORD_C, {8'h00, OP_SEL_WIN, 4'h3});
        h.wr(WORD_D, 16'h00FF);
        h.wr(WORD_A, {6'h00, 2'h2, OP_ARM, 4'h0});
        cmp_bit(irq, 1'b0);
        h.ack(p);
        cmp_bit(p, 1'b1);
        close_out();
    end
endmodule : dgvic_top_test
`default_nettype wire
